// [hdl/dgr_pkg.sv]
// Constants and carrier types for the decoder gate, raw data and status register slice
package dgr_pkg;

	// Register subaddresses
	localparam logic [7:0] ADDR_GATE_START_LOW = 8'h15;
	localparam logic [7:0] ADDR_GATE_STOP_LOW = 8'h16;
	localparam logic [7:0] ADDR_MISC_GATE_MSBS = 8'h17;
	localparam logic [7:0] ADDR_RAW_GAIN = 8'h18;
	localparam logic [7:0] ADDR_RAW_OFFSET = 8'h19;
	localparam logic [7:0] ADDR_STATUS_ONE = 8'h1e;
	localparam logic [7:0] ADDR_STATUS_TWO = 8'h1f;

	// Field positions inside misc_gate_msbs
	localparam int MISC_START_MSB = 0;
	localparam int MISC_STOP_MSB = 1;
	localparam int MISC_ALT_POS = 2;
	localparam int MISC_LAT_LO = 3;
	localparam int MISC_LAT_HI = 5;
	localparam int MISC_HALF_LLC_DIS = 6;
	localparam int MISC_LLC_DIS = 7;

	// Values after reset
	localparam logic [7:0] RST_GATE_START_LOW = 8'h00;
	localparam logic [7:0] RST_GATE_STOP_LOW = 8'h00;
	localparam logic [7:0] RST_MISC_GATE_MSBS = 8'h18;
	localparam logic [7:0] RST_RAW_GAIN = 8'h80;
	localparam logic [7:0] RST_RAW_OFFSET = 8'h80;

	// Frame line counting limits
	localparam logic [8:0] LINE_MAX_50 = 9'h136;
	localparam logic [8:0] LINE_MAX_60 = 9'h104;

	// Search latency: reserved code and the value used in its place
	localparam logic [2:0] LAT_RESERVED = 3'h0;
	localparam logic [2:0] LAT_DEFAULT = 3'h3;

	// Output format that blanks fields by the gate window
	localparam logic [2:0] FMT_GATE_BLANK = 3'h1;

	// Raw data arithmetic
	localparam logic [10:0] RAW_OFFSET_ZERO = 11'h080;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} dgr_req_type;

	typedef struct packed {
		logic line_tick;
		logic field_tick;
		logic second_field;
	} dgr_timing_type;

	typedef struct packed {
		logic horiz_unlocked_flag;
		logic slow_constant_flag;
		logic gain_top_limit_flag;
		logic gain_bottom_limit_flag;
		logic white_peak_active;
		logic [1:0] colour_standard_found;
		logic interlace_flag;
		logic loops_unlocked_flag;
		logic field_rate_flag;
		logic stripe_four_line_flag;
		logic colour_stripe_flag;
		logic copy_protect_flag;
		logic capture_ready_flag;
	} dgr_status_type;

endpackage

// [hdl/dgr_raw_scale.sv]
// Raw data gain and offset stage with saturation
`timescale 1ns/100ps
module dgr_raw_scale (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [7:0] sample,
	input wire logic sample_valid,
	input wire logic [7:0] raw_gain_value,
	input wire logic [7:0] raw_offset_value,
	output logic [7:0] scaled,
	output logic scaled_valid
);
	logic [15:0] prod;
	logic [10:0] sum;
	logic [7:0] sat;

	// Gain of 128 is unity, so the product is shifted by seven
	assign prod = sample * raw_gain_value;
	assign sum = {2'h0, prod[15:7]} + {3'h0, raw_offset_value} - dgr_pkg::RAW_OFFSET_ZERO;

	always_comb begin
		if (sum[10])
			sat = 8'h00;
		else if (sum[9:8] != 2'h0)
			sat = 8'hff;
		else
			sat = sum[7:0];
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			scaled <= 8'h00;
			scaled_valid <= 1'b0;
		end else begin
			scaled_valid <= sample_valid;
			if (sample_valid)
				scaled <= sat;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	AST_RAW_OFF: assert property (
		sample_valid && raw_gain_value == 8'h00 |=> scaled ==
		(($past(raw_offset_value) < 8'h80) ? 8'h00 : $past(raw_offset_value) - 8'h80))
		else $error("Zero gain did not switch raw data off");
	AST_RAW_UNITY: assert property (
		sample_valid && raw_gain_value == 8'h80 && raw_offset_value == 8'h80
		|=> scaled == $past(sample))
		else $error("Nominal gain with zero offset changed the sample");
endmodule

// [hdl/dgr_regs.sv]
// Gate window, line clock enables, search latency, raw data controls and status bytes
`timescale 1ns/100ps
// Overview of operation
// - Gate rises and field ident toggles at 9-bit start line (17H bit0, 15H).
// - Start line counts frame lines, 0..310 at 50 Hz, 0..260 at 60 Hz.
// - Gate falls at 9-bit stop line (17H bit1, 16H).
// - 17H bit7 zero drives line clock, one floats it; bit6 likewise half rate.
// - Search step waits 1..7 fields from bits 5..3; 000 reserved, 011 recommended.
// - Alternative-position bit moves the gate one line earlier in field 2.
// - Raw data scaled by gain at 18H; 128 nominal, 255 double, 0 off.
// - Raw data gets offset-binary 19H added; 80h adds nothing.
// - Status byte one at 1EH read-only; low bits give detected colour standard.
// - Status one bit6 reads 1 while horizontal frequency is unlocked.
// - Status one bit5 set while slow time constant active in white-peak mode.
// - Bit4 set while luma gain at maximum, bit3 while at minimum.
// - Status one bit2 set while white peak loop is active.
// - Status byte two at 1FH read-only, bit4 unused; bit7 shows interlace.
// - Status two bit6 zero only when horizontal and vertical loops locked.
// - Status two bit5 gives field rate, zero 50 Hz, one 60 Hz.
// - Status two bit3 set for four-line type 3 colour stripe.
// - Status two bit2 set for any colour stripe.
// - Status two bit1 set for copy-protected source up to version 7.01.
// - Status two bit0 set when all loops locked and capture ready.
// - Gate-blanking output format places field blanking by the gate window.
module dgr_regs (
	input wire logic clk,
	input wire logic resetn,
	input wire dgr_pkg::dgr_req_type bus_req,
	output logic [7:0] bus_rdata,
	output logic bus_rvalid,
	input wire dgr_pkg::dgr_timing_type timing,
	input wire dgr_pkg::dgr_status_type status,
	input wire logic [2:0] output_format_select,
	input wire logic std_blank_in,
	input wire logic [7:0] raw_in,
	input wire logic raw_in_valid,
	output logic [7:0] raw_out,
	output logic raw_out_valid,
	output logic vertical_gate_out,
	output logic field_ident_out,
	output logic field_blank_out,
	output logic line_clock_out_oe,
	output logic half_rate_line_locked_clock,
	output logic half_line_clock_out_oe,
	output logic search_step_pulse
);
	logic [7:0] start_low_r;
	logic [7:0] stop_low_r;
	logic [7:0] misc_r;
	logic [7:0] gain_r;
	logic [7:0] offset_r;
	logic [8:0] gate_start_line;
	logic [8:0] gate_stop_line;
	logic gate_alt_position;
	logic line_clock_out_disable;
	logic half_line_clock_out_disable;
	logic [2:0] detect_search_latency;
	logic [2:0] lat_eff;
	logic [8:0] start_eff;
	logic [8:0] stop_eff;
	logic [8:0] line_max;
	logic [8:0] line_cnt_r;
	logic [8:0] line_cnt_nxt;
	logic line_hit;
	logic [2:0] fld_cnt_r;
	logic [7:0] status_one;
	logic [7:0] status_two;

	// Gate line after the alternative position is applied
	function automatic logic [8:0] eff_line(input logic [8:0] line, input logic alt,
		input logic second);
		if (alt && second && line != 9'h000)
			return line - 9'h001;
		return line;
	endfunction

	assign gate_start_line = {misc_r[dgr_pkg::MISC_START_MSB], start_low_r};
	assign gate_stop_line = {misc_r[dgr_pkg::MISC_STOP_MSB], stop_low_r};
	assign gate_alt_position = misc_r[dgr_pkg::MISC_ALT_POS];
	assign line_clock_out_disable = misc_r[dgr_pkg::MISC_LLC_DIS];
	assign half_line_clock_out_disable = misc_r[dgr_pkg::MISC_HALF_LLC_DIS];
	assign detect_search_latency = misc_r[dgr_pkg::MISC_LAT_HI:dgr_pkg::MISC_LAT_LO];

	assign start_eff = eff_line(gate_start_line, gate_alt_position, timing.second_field);
	assign stop_eff = eff_line(gate_stop_line, gate_alt_position, timing.second_field);

	// Status bytes are assembled live from the detector flags
	assign status_one = {1'b0, status.horiz_unlocked_flag, status.slow_constant_flag,
		status.gain_top_limit_flag, status.gain_bottom_limit_flag,
		status.white_peak_active, status.colour_standard_found};
	assign status_two = {status.interlace_flag, status.loops_unlocked_flag,
		status.field_rate_flag, 1'b0, status.stripe_four_line_flag,
		status.colour_stripe_flag, status.copy_protect_flag,
		status.capture_ready_flag};

	// Register writes; status locations fall through and are ignored
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			start_low_r <= dgr_pkg::RST_GATE_START_LOW;
			stop_low_r <= dgr_pkg::RST_GATE_STOP_LOW;
			misc_r <= dgr_pkg::RST_MISC_GATE_MSBS;
			gain_r <= dgr_pkg::RST_RAW_GAIN;
			offset_r <= dgr_pkg::RST_RAW_OFFSET;
		end else if (bus_req.wr) begin
			unique case (bus_req.addr)
				dgr_pkg::ADDR_GATE_START_LOW: start_low_r <= bus_req.wdata;
				dgr_pkg::ADDR_GATE_STOP_LOW: stop_low_r <= bus_req.wdata;
				dgr_pkg::ADDR_MISC_GATE_MSBS: misc_r <= bus_req.wdata;
				dgr_pkg::ADDR_RAW_GAIN: gain_r <= bus_req.wdata;
				dgr_pkg::ADDR_RAW_OFFSET: offset_r <= bus_req.wdata;
				default: begin
				end
			endcase
		end
	end

	// Register reads, answered one cycle after the strobe
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			bus_rdata <= 8'h00;
			bus_rvalid <= 1'b0;
		end else begin
			bus_rvalid <= bus_req.rd;
			if (bus_req.rd) begin
				unique case (bus_req.addr)
					dgr_pkg::ADDR_GATE_START_LOW: bus_rdata <= start_low_r;
					dgr_pkg::ADDR_GATE_STOP_LOW: bus_rdata <= stop_low_r;
					dgr_pkg::ADDR_MISC_GATE_MSBS: bus_rdata <= misc_r;
					dgr_pkg::ADDR_RAW_GAIN: bus_rdata <= gain_r;
					dgr_pkg::ADDR_RAW_OFFSET: bus_rdata <= offset_r;
					dgr_pkg::ADDR_STATUS_ONE: bus_rdata <= status_one;
					dgr_pkg::ADDR_STATUS_TWO: bus_rdata <= status_two;
					default: bus_rdata <= 8'h00;
				endcase
			end
		end
	end

	// Frame line counter; it holds at the last line so a missing field tick
	// cannot wrap it into a false gate edge
	assign line_max = status.field_rate_flag ? dgr_pkg::LINE_MAX_60 : dgr_pkg::LINE_MAX_50;

	always_comb begin
		line_cnt_nxt = line_cnt_r;
		if (timing.field_tick)
			line_cnt_nxt = 9'h000;
		else if (timing.line_tick && line_cnt_r < line_max)
			line_cnt_nxt = line_cnt_r + 9'h001;
	end

	assign line_hit = timing.field_tick || (timing.line_tick && line_cnt_nxt != line_cnt_r);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			line_cnt_r <= 9'h000;
		else
			line_cnt_r <= line_cnt_nxt;
	end

	// Start wins when start and stop lines coincide
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			vertical_gate_out <= 1'b0;
		end else if (line_hit) begin
			if (line_cnt_nxt == start_eff)
				vertical_gate_out <= 1'b1;
			else if (line_cnt_nxt == stop_eff)
				vertical_gate_out <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			field_ident_out <= 1'b0;
		else if (line_hit && line_cnt_nxt == start_eff)
			field_ident_out <= ~field_ident_out;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			field_blank_out <= 1'b1;
		else if (output_format_select == dgr_pkg::FMT_GATE_BLANK)
			field_blank_out <= ~vertical_gate_out;
		else
			field_blank_out <= std_blank_in;
	end

	// Line clock enables and the half-rate clock from a divider
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			line_clock_out_oe <= 1'b0;
			half_line_clock_out_oe <= 1'b0;
		end else begin
			line_clock_out_oe <= ~line_clock_out_disable;
			half_line_clock_out_oe <= ~half_line_clock_out_disable;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			half_rate_line_locked_clock <= 1'b0;
		else
			half_rate_line_locked_clock <= ~half_rate_line_locked_clock;
	end

	// Search latency; the reserved code runs at the recommended three fields
	assign lat_eff = (detect_search_latency == dgr_pkg::LAT_RESERVED) ?
		dgr_pkg::LAT_DEFAULT : detect_search_latency;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			fld_cnt_r <= 3'h0;
			search_step_pulse <= 1'b0;
		end else begin
			search_step_pulse <= 1'b0;
			if (timing.field_tick) begin
				if (fld_cnt_r + 3'h1 >= lat_eff) begin
					fld_cnt_r <= 3'h0;
					search_step_pulse <= 1'b1;
				end else begin
					fld_cnt_r <= fld_cnt_r + 3'h1;
				end
			end
		end
	end

	dgr_raw_scale u_raw (
		.clk(clk),
		.resetn(resetn),
		.sample(raw_in),
		.sample_valid(raw_in_valid),
		.raw_gain_value(gain_r),
		.raw_offset_value(offset_r),
		.scaled(raw_out),
		.scaled_valid(raw_out_valid)
	);

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	sequence seq_misc_write;
		bus_req.wr && bus_req.addr == dgr_pkg::ADDR_MISC_GATE_MSBS;
	endsequence

	sequence seq_status_read(logic [7:0] a);
		bus_req.rd && bus_req.addr == a;
	endsequence

	AST_GATE_RISE: assert property (
		line_hit && line_cnt_nxt == start_eff |=> vertical_gate_out)
		else $error("Gate did not rise at start line");
	AST_GATE_FALL: assert property (
		line_hit && line_cnt_nxt == stop_eff && line_cnt_nxt != start_eff
		|=> !vertical_gate_out)
		else $error("Gate did not fall at stop line");
	AST_FID_TOGGLE: assert property (
		line_hit && line_cnt_nxt == start_eff |=> field_ident_out != $past(field_ident_out))
		else $error("Field ident did not toggle at start line");
	AST_LINE_RANGE: assert property (
		line_cnt_r <= dgr_pkg::LINE_MAX_50)
		else $error("Line counter beyond frame range");
	AST_ALT_EARLY: assert property (
		gate_alt_position && timing.second_field && gate_start_line != 9'h000
		|-> start_eff == gate_start_line - 9'h001)
		else $error("Alternative gate position not one line earlier");
	AST_LLC_OE: assert property (
		seq_misc_write ##1 !bus_req.wr |=> line_clock_out_oe == ~misc_r[7]
		&& half_line_clock_out_oe == ~misc_r[6])
		else $error("Line clock enables do not follow register");
	AST_LAT_STEP: assert property (
		timing.field_tick && fld_cnt_r + 3'h1 >= lat_eff |=> search_step_pulse
		##1 !search_step_pulse)
		else $error("Search step pulse missing or too long");
	AST_STATUS_ONE: assert property (
		seq_status_read(dgr_pkg::ADDR_STATUS_ONE) |=> bus_rvalid
		&& bus_rdata == {1'b0, $past(status.horiz_unlocked_flag), $past(status_one[5:0])})
		else $error("Status byte one wrong");
	AST_STATUS_TWO: assert property (
		seq_status_read(dgr_pkg::ADDR_STATUS_TWO) |=> bus_rvalid && !bus_rdata[4]
		&& bus_rdata[6] == $past(status.loops_unlocked_flag)
		&& bus_rdata[0] == $past(status.capture_ready_flag))
		else $error("Status byte two wrong");
	AST_RO_WRITE: assert property (
		bus_req.wr && (bus_req.addr == dgr_pkg::ADDR_STATUS_ONE
		|| bus_req.addr == dgr_pkg::ADDR_STATUS_TWO)
		|=> $stable(misc_r) && $stable(gain_r) && $stable(offset_r) && $stable(start_low_r))
		else $error("Write to status location changed a register");
	AST_BLANK: assert property (
		output_format_select == dgr_pkg::FMT_GATE_BLANK |=> field_blank_out
		== ~$past(vertical_gate_out))
		else $error("Gate blanking does not follow gate");

	sequence seq_line_step;
		timing.line_tick && !timing.field_tick;
	endsequence

	AST_LINE_ZERO: assert property (
		timing.field_tick |=> line_cnt_r == 9'h000)
		else $error("Field start did not clear the line counter");
	AST_LINE_STEP: assert property (
		seq_line_step ##0 line_cnt_r < line_max
		|=> line_cnt_r == $past(line_cnt_r) + 9'h001)
		else $error("Line counter did not advance on a line start");
	AST_LINE_HOLD: assert property (
		seq_line_step ##0 line_cnt_r >= line_max |=> $stable(line_cnt_r))
		else $error("Line counter moved past the last frame line");
	AST_IDLE_HOLD: assert property (
		!line_hit |=> $stable(vertical_gate_out) && $stable(field_ident_out))
		else $error("Gate or field ident moved without a line start");
	AST_ALT_OFF: assert property (
		!gate_alt_position || !timing.second_field
		|-> start_eff == gate_start_line && stop_eff == gate_stop_line)
		else $error("Gate lines moved without the alternative position");
	AST_STEP_QUIET: assert property (
		!timing.field_tick |=> !search_step_pulse)
		else $error("Search step without a field start");
	AST_HALF_CLK: assert property (
		1'b1 |=> half_rate_line_locked_clock != $past(half_rate_line_locked_clock))
		else $error("Half rate line clock did not toggle");
	AST_RD_VALID: assert property (
		bus_req.rd |=> bus_rvalid)
		else $error("Read strobe not answered next cycle");
	AST_RD_QUIET: assert property (
		!bus_req.rd |=> !bus_rvalid && $stable(bus_rdata))
		else $error("Read data moved without a read strobe");
	AST_WR_GAIN: assert property (
		bus_req.wr && bus_req.addr == dgr_pkg::ADDR_RAW_GAIN
		|=> gain_r == $past(bus_req.wdata))
		else $error("Raw gain write did not land");
	AST_WR_OFFSET: assert property (
		bus_req.wr && bus_req.addr == dgr_pkg::ADDR_RAW_OFFSET
		|=> offset_r == $past(bus_req.wdata))
		else $error("Raw offset write did not land");
	AST_WR_START: assert property (
		bus_req.wr && bus_req.addr == dgr_pkg::ADDR_GATE_START_LOW
		|=> start_low_r == $past(bus_req.wdata))
		else $error("Gate start write did not land");
	AST_WR_STOP: assert property (
		bus_req.wr && bus_req.addr == dgr_pkg::ADDR_GATE_STOP_LOW
		|=> stop_low_r == $past(bus_req.wdata))
		else $error("Gate stop write did not land");
	AST_BLANK_STD: assert property (
		output_format_select != dgr_pkg::FMT_GATE_BLANK
		|=> field_blank_out == $past(std_blank_in))
		else $error("Standard blanking not passed through");
endmodule

// [verification/dgr_host.sv]
// Control bus host model that programs and polls the register slice
`timescale 1ns/100ps
module dgr_host (
	input wire logic clk,
	output dgr_pkg::dgr_req_type bus_req,
	input wire logic [7:0] bus_rdata,
	input wire logic bus_rvalid
);
	initial bus_req = '0;

	task automatic write(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk) bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk) begin
			bus_req.wr <= 1'b0;
			// Released data lines carry junk, not the last value
			bus_req.wdata <= ~d;
		end
	endtask

	// Strobe is a one-cycle pulse; the answer is polled for a bounded time
	task automatic read(input logic [7:0] a, output logic [7:0] d, output logic ok);
		ok = 1'b0;
		d = 8'hxx;
		@(posedge clk) bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk) bus_req.rd <= 1'b0;
		for (int i = 0; i < 8 && !ok; i++) begin
			@(negedge clk);
			if (bus_rvalid === 1'b1) begin
				d = bus_rdata;
				ok = 1'b1;
			end
		end
	endtask
endmodule

// [verification/testbench.sv]
// Self-checking bench for the gate, raw data and status register slice
`timescale 1ns/100ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin mismatches++; \
	$display("wrong value at %0t: %h vs %h", $time, (a), (e)); end end
module testbench;
	typedef struct packed {
		logic [7:0] addr;
		logic do_wr;
		logic [7:0] wdata;
		dgr_pkg::dgr_status_type stat;
		logic [7:0] exp;
	} dgr_row_type;

	logic clk = 1'b0;
	logic resetn = 1'b0;
	dgr_pkg::dgr_req_type bus_req;
	logic [7:0] bus_rdata;
	logic bus_rvalid;
	dgr_pkg::dgr_timing_type timing = '0;
	dgr_pkg::dgr_status_type status = '0;
	logic [2:0] fmt = 3'h1;
	logic std_blank = 1'b0;
	logic [7:0] raw_in = 8'h00;
	logic raw_in_valid = 1'b0;
	logic [7:0] raw_out;
	logic raw_out_valid, gate, ident, blank, oe, half_clk, half_oe, step;
	int mismatches = 0;
	int comparisons = 0;
	int pulses = 0;
	int base;
	logic [7:0] rd;
	logic ok, id0, prev;
	logic [7:0] v;
	dgr_row_type rows [14];
	logic [23:0] raws [4];
	int lats [4];

	always #20 clk = ~clk;
	always @(posedge clk) if (step === 1'b1) pulses <= pulses + 1;

	dgr_regs dut_u (.clk(clk), .resetn(resetn), .bus_req(bus_req), .bus_rdata(bus_rdata),
		.bus_rvalid(bus_rvalid), .timing(timing), .status(status),
		.output_format_select(fmt), .std_blank_in(std_blank), .raw_in(raw_in),
		.raw_in_valid(raw_in_valid), .raw_out(raw_out), .raw_out_valid(raw_out_valid),
		.vertical_gate_out(gate), .field_ident_out(ident), .field_blank_out(blank),
		.line_clock_out_oe(oe), .half_rate_line_locked_clock(half_clk),
		.half_line_clock_out_oe(half_oe), .search_step_pulse(step));
	dgr_host host_u (.clk(clk), .bus_req(bus_req), .bus_rdata(bus_rdata),
		.bus_rvalid(bus_rvalid));

	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic rchk(input logic [7:0] a);
		host_u.read(a, rd, ok);
		if (ok !== 1'b1) begin
			mismatches++;
			end_sim;
		end
	endtask

	task automatic tick(input logic fld);
		@(posedge clk) begin
			timing.field_tick <= fld;
			timing.line_tick <= ~fld;
		end
		@(posedge clk) begin
			timing.field_tick <= 1'b0;
			timing.line_tick <= 1'b0;
		end
	endtask

	task automatic settle;
		repeat (2) @(posedge clk);
		@(negedge clk);
	endtask

	function automatic logic [7:0] raw_exp(input logic [7:0] x, g, o);
		int t;
		t = ((int'(x) * int'(g)) >> 7) + int'(o) - 128;
		if (t < 0) t = 0;
		if (t > 255) t = 255;
		return t[7:0];
	endfunction

	initial begin
		rows = '{'{8'h15, 1'b0, 8'h00, 14'h0000, 8'h00}, '{8'h17, 1'b0, 8'h00, 14'h0000, 8'h18},
			'{8'h18, 1'b0, 8'h00, 14'h0000, 8'h80}, '{8'h19, 1'b0, 8'h00, 14'h0000, 8'h80},
			'{8'h15, 1'b1, 8'ha5, 14'h0000, 8'ha5}, '{8'h16, 1'b1, 8'h3c, 14'h0000, 8'h3c},
			'{8'h1e, 1'b1, 8'hff, 14'h3fff, 8'h7f}, '{8'h1f, 1'b1, 8'h00, 14'h3fff, 8'hef},
			'{8'h1e, 1'b0, 8'h00, 14'h0000, 8'h00}, '{8'h1f, 1'b0, 8'h00, 14'h0055, 8'ha5},
			'{8'h1e, 1'b0, 8'h00, 14'h0055, 8'h00}, '{8'h1e, 1'b0, 8'h00, 14'h2a80, 8'h55},
			'{8'h1e, 1'b0, 8'h00, 14'h1500, 8'h2a}, '{8'h2a, 1'b1, 8'h77, 14'h0000, 8'h00}};
		raws = '{24'h64ff00, 24'hc8ffff, 24'h808080, 24'hff0000};
		lats = '{1, 3, 0, 7};
		repeat (8) @(posedge clk);
		`CHK(blank, 1'b1)
		resetn <= 1'b1;
		foreach (rows[i]) begin
			@(posedge clk) status <= rows[i].stat;
			if (rows[i].do_wr) host_u.write(rows[i].addr, rows[i].wdata);
			rchk(rows[i].addr);
			`CHK(rd, rows[i].exp)
		end
		foreach (raws[i]) begin
			host_u.write(8'h18, raws[i][15:8]);
			host_u.write(8'h19, raws[i][7:0]);
			@(posedge clk) begin
				raw_in <= raws[i][23:16];
				raw_in_valid <= 1'b1;
			end
			@(posedge clk) raw_in_valid <= 1'b0;
			@(negedge clk);
			`CHK(raw_out_valid, 1'b1)
			`CHK(raw_out, raw_exp(raws[i][23:16], raws[i][15:8], raws[i][7:0]))
		end
		for (int k = 0; k < 4; k++) begin
			v = {k[1:0], 6'h18};
			host_u.write(8'h17, v);
			settle();
			`CHK(oe, ~v[7])
			`CHK(half_oe, ~v[6])
			prev = half_clk;
			@(negedge clk);
			`CHK(half_clk, ~prev)
		end
		@(posedge clk) status <= '0;
		host_u.write(8'h15, 8'h02);
		host_u.write(8'h16, 8'h04);
		tick(1'b1);
		tick(1'b0);
		settle();
		`CHK(gate, 1'b0)
		id0 = ident;
		tick(1'b0);
		settle();
		`CHK(gate, 1'b1)
		`CHK(ident, ~id0)
		`CHK(blank, 1'b0)
		tick(1'b0);
		tick(1'b0);
		settle();
		`CHK(gate, 1'b0)
		`CHK(blank, 1'b1)
		host_u.write(8'h17, 8'h1c);
		@(posedge clk) timing.second_field <= 1'b1;
		tick(1'b1);
		tick(1'b0);
		settle();
		`CHK(gate, 1'b1)
		@(posedge clk) timing.second_field <= 1'b0;
		host_u.write(8'h15, 8'h36);
		host_u.write(8'h17, 8'h19);
		tick(1'b1);
		repeat (315) tick(1'b0);
		settle();
		`CHK(gate, 1'b1)
		@(posedge clk) status.field_rate_flag <= 1'b1;
		tick(1'b1);
		repeat (315) tick(1'b0);
		settle();
		`CHK(gate, 1'b0)
		foreach (lats[i]) begin
			host_u.write(8'h17, {2'h0, lats[i][2:0], 3'h0});
			repeat (21) tick(1'b1);
			settle();
			base = pulses;
			repeat (21) tick(1'b1);
			settle();
			`CHK(pulses - base, 21 / ((lats[i] == 0) ? 3 : lats[i]))
		end
		// Gate is low here, so the gate-blanking value would be the opposite of std_blank
		@(posedge clk) fmt <= 3'h0;
		settle();
		`CHK(blank, 1'b0)
		@(posedge clk) std_blank <= 1'b1;
		settle();
		`CHK(blank, 1'b1)
		@(posedge clk) fmt <= 3'h1;
		@(posedge clk) resetn <= 1'b0;
		@(negedge clk);
		`CHK(blank, 1'b1)
		`CHK({gate, ident, oe, half_oe, half_clk, step, raw_out_valid}, 7'h00)
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		rchk(8'h17);
		`CHK(rd, 8'h18)
		rchk(8'h15);
		`CHK(rd, 8'h00)
		`CHK(oe, 1'b1)
		end_sim();
	end
endmodule
